// *** bpg_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing figures of the
 * breath pattern and group control block.
 * Assumes a 250 MHz core clock and an 8-bit register port in front of it.
 */
`ifndef BPG_REGS_SVH
`define BPG_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define BPG_ADDR_CFG 8'ha0
`define BPG_ADDR_RUN 8'ha1
`define BPG_ADDR_T1 8'ha3
`define BPG_ADDR_C1 8'ha4
`define BPG_ADDR_C2 8'ha5
`define BPG_ADDR_MAX 8'ha6
`define BPG_ADDR_MIN 8'ha7
`define BPG_ADDR_RED 8'ha8
`define BPG_ADDR_GRN 8'ha9
`define BPG_ADDR_BLU 8'haa
`define BPG_ADDR_GE 8'hab
`define BPG_RST_BYTE 8'h00

////////////////////////////////////////////////////////////////////////////////
// field positions
`define BPG_CFG_EN 0
`define BPG_CFG_AUTO 1
`define BPG_CFG_SWITCH 3
`define BPG_CFG_MASK 8'h0f
`define BPG_RUN_BIT 0
`define BPG_RUNNING_BIT 1
`define BPG_DONE_BIT 2
`define BPG_FALL_MSB 7
`define BPG_FALL_LSB 4
`define BPG_OFF_MSB 3
`define BPG_OFF_LSB 0
`define BPG_END_MSB 7
`define BPG_END_LSB 6
`define BPG_START_MSB 5
`define BPG_START_LSB 4
`define BPG_RPT_HI_MSB 3
`define BPG_RPT_HI_LSB 0
`define BPG_START_RISE 2'h0
`define BPG_START_ON 2'h1
`define BPG_START_FALL 2'h2
`define BPG_END_OFF 2'h0

////////////////////////////////////////////////////////////////////////////////
// timing: phase times are counted in ticks of 10 ms
`define BPG_CLK_NS 4
`define BPG_TICK_NS 10000000
`define BPG_TICK_CYCLES (`BPG_TICK_NS / `BPG_CLK_NS)
`define BPG_DUR_W 10
`define BPG_RAMP_TBL {10'h33e, 10'h2da, 10'h26c, 10'h208, 10'h1a4, 10'h136, 10'h104, 10'h0d2, \
                      10'h0a0, 10'h068, 10'h04d, 10'h033, 10'h026, 10'h01a, 10'h00d, 10'h000}
`define BPG_HOLD_ZERO_TICKS 10'h004

`endif

// *** bpg_pkg.sv ***
/*
 * Types shared by the breath pattern and group control modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bpg_pkg;
   typedef enum logic [2:0] {PH_IDLE, PH_RISE, PH_ON, PH_FALL, PH_OFF} bpg_phase_t;
   typedef logic [7:0] bpg_byte_t;
endpackage : bpg_pkg

// *** bpg_phase_timer.sv ***
/*
 * Phase duration timer: turns a 4-bit time code into a count of 10 ms ticks
 * and signals when the phase has run out.
 * Assumes one tick pulse per 10 ms from the parent and a load pulse per phase.
 */
`include "bpg_regs.svh"

module bpg_phase_timer import bpg_pkg::*; (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // phase control
   input wire logic tick,
   input wire logic load,
   input wire logic halt,
   input wire logic hold_sel,
   input wire logic [3:0] code,
   // status
   output logic done,
   output logic [`BPG_DUR_W-1:0] dur
);

   localparam logic [16*`BPG_DUR_W-1:0] RAMP_TBL = `BPG_RAMP_TBL;

   logic armed;
   logic [`BPG_DUR_W-1:0] remain;
   wire [`BPG_DUR_W-1:0] tbl_val = RAMP_TBL[code*`BPG_DUR_W +: `BPG_DUR_W];
   // hold phases share the ramp table except that code zero is never zero long
   wire [`BPG_DUR_W-1:0] new_dur = (hold_sel && code == 4'h0) ? `BPG_HOLD_ZERO_TICKS : tbl_val;

   assign done = armed && remain == '0;

   always_ff @(posedge mclk) begin
      if (rst) begin
         armed <= 1'b0;
         remain <= '0;
         dur <= '0;
      end else if (halt) begin
         armed <= 1'b0;
      end else if (load) begin
         armed <= 1'b1;
         remain <= new_dur;
         dur <= new_dur;
      end else if (done) begin
         armed <= 1'b0;
      end else if (tick && remain != '0) begin
         remain <= remain - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   AST_FALL_ZERO: assert property (load && !halt && !hold_sel && code == 4'h0 |=> done)
      else $error("zero fall code did not end the phase at once");
   AST_FALL_LONGEST: assert property (load && !halt && !hold_sel && code == 4'hf |=> dur == 10'h33e)
      else $error("longest fall code gave the wrong tick count");
   AST_HOLD_ZERO: assert property (load && !halt && hold_sel && code == 4'h0 |=> !done ##0 remain == 10'h004)
      else $error("zero hold-off code did not give four ticks");

endmodule : bpg_phase_timer

// *** bpg_triple_decode.sv ***
/*
 * Triple mode decoder: spreads the eight triple enable bits over LED1 to
 * LED24 as group or pattern masks, registered.
 * Assumes the enable bits and the controller enable come from the register file.
 */
module bpg_triple_decode import bpg_pkg::*; (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // settings
   input wire logic [7:0] triple_mode_enable,
   input wire logic pattern_controller_enable,
   // masks, bit k is LED k+1
   output logic [23:0] group_led_mask,
   output logic [23:0] pattern_led_mask
);

   // one register per mask keeps every bit with a single driving process
   wire [23:0] next_group_led_mask;
   wire [23:0] next_pattern_led_mask;

   genvar n;
   generate
      for (n = 0; n < 8; n = n + 1) begin : g_triple
         assign next_group_led_mask[3*n +: 3] = {3{triple_mode_enable[n] & ~pattern_controller_enable}};
         assign next_pattern_led_mask[3*n +: 3] = {3{triple_mode_enable[n] & pattern_controller_enable}};
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (rst) begin
         group_led_mask <= '0;
         pattern_led_mask <= '0;
      end else begin
         group_led_mask <= next_group_led_mask;
         pattern_led_mask <= next_pattern_led_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   AST_GROUP_MAP: assert property (!pattern_controller_enable ##1 !$past(rst) |->
      group_led_mask[5:3] == {3{$past(triple_mode_enable[1])}} && pattern_led_mask == 24'h0)
      else $error("group mask does not follow the enable bits");
   AST_PATTERN_MAP: assert property (pattern_controller_enable ##1 !$past(rst) |->
      pattern_led_mask[23:21] == {3{$past(triple_mode_enable[7])}} && group_led_mask == 24'h0)
      else $error("pattern mask does not follow the enable bits");

endmodule : bpg_triple_decode

// *** bpg_breath_ctrl.sv ***
/*
 * Auto-breath pattern sequencer with its register file, brightness ramp and
 * group colour and triple mode settings.
 * Assumes an 8-bit register port driven by the serial interface engine, with
 * one-cycle read and write strobes, and rise and on-hold codes supplied by
 * the neighbouring timer register.
 */
// How it works
// - fall code sets ramp-down time, 0 to 8.3s
// - hold-off code sets minimum hold, from 0.04s
// - end point 00 rests off, else on
// - start point picks the first loop phase
// - repeat count: four high bits plus eight low
// - zero repeat count loops forever, never ends
// - maximum level tops ramp and on-hold
// - minimum level bottoms ramp and off-hold
// - three shared colour registers, reset to zero
// - controller off: enable bit puts triple in group
// - controller on: enable bit puts triple in pattern
// - controller enable selects meaning of triple bits
// - mode bit: manual at reset, or automatic
// - done flag set at end, cleared by read
`include "bpg_regs.svh"

module bpg_breath_ctrl import bpg_pkg::*; #(
   parameter int unsigned TICK_CYCLES = `BPG_TICK_CYCLES
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // rise and on-hold codes from the neighbouring timer register
   input wire logic [3:0] rise_code,
   input wire logic [3:0] on_code,
   // led side
   output logic [7:0] breath_level,
   output bpg_byte_t shared_red_mix,
   output bpg_byte_t shared_green_mix,
   output bpg_byte_t shared_blue_mix,
   output logic [23:0] group_led_mask,
   output logic [23:0] pattern_led_mask,
   // status
   output logic pattern_running,
   output logic loop_done_flag
);

   ////////////////////////////////////////////////////////////////////////////
   // register file
   bpg_byte_t pattern_config;
   bpg_byte_t pattern_fall_hold_off_timer;
   bpg_byte_t pattern_loop_endpoints_count_high;
   bpg_byte_t pattern_repeat_count_low;
   bpg_byte_t breath_max_brightness;
   bpg_byte_t breath_min_brightness;
   bpg_byte_t triple_mode_enable_low;
   logic run_bit;

   wire wr_cfg = reg_wr && reg_addr == `BPG_ADDR_CFG;
   wire wr_run = reg_wr && reg_addr == `BPG_ADDR_RUN;
   wire wr_t1 = reg_wr && reg_addr == `BPG_ADDR_T1;
   wire wr_c1 = reg_wr && reg_addr == `BPG_ADDR_C1;
   wire wr_c2 = reg_wr && reg_addr == `BPG_ADDR_C2;
   wire wr_max = reg_wr && reg_addr == `BPG_ADDR_MAX;
   wire wr_min = reg_wr && reg_addr == `BPG_ADDR_MIN;
   wire wr_red = reg_wr && reg_addr == `BPG_ADDR_RED;
   wire wr_grn = reg_wr && reg_addr == `BPG_ADDR_GRN;
   wire wr_blu = reg_wr && reg_addr == `BPG_ADDR_BLU;
   wire wr_ge = reg_wr && reg_addr == `BPG_ADDR_GE;
   wire rd_run = reg_rd && reg_addr == `BPG_ADDR_RUN;

   always_ff @(posedge mclk) begin
      if (rst) begin
         pattern_config <= `BPG_RST_BYTE;
         run_bit <= 1'b0;
         pattern_fall_hold_off_timer <= `BPG_RST_BYTE;
         pattern_loop_endpoints_count_high <= `BPG_RST_BYTE;
         pattern_repeat_count_low <= `BPG_RST_BYTE;
         breath_max_brightness <= `BPG_RST_BYTE;
         breath_min_brightness <= `BPG_RST_BYTE;
         shared_red_mix <= `BPG_RST_BYTE;
         shared_green_mix <= `BPG_RST_BYTE;
         shared_blue_mix <= `BPG_RST_BYTE;
         triple_mode_enable_low <= `BPG_RST_BYTE;
      end else begin
         if (wr_cfg) pattern_config <= reg_wdata & `BPG_CFG_MASK;
         if (wr_run) run_bit <= reg_wdata[`BPG_RUN_BIT];
         if (wr_t1) pattern_fall_hold_off_timer <= reg_wdata;
         if (wr_c1) pattern_loop_endpoints_count_high <= reg_wdata;
         if (wr_c2) pattern_repeat_count_low <= reg_wdata;
         if (wr_max) breath_max_brightness <= reg_wdata;
         if (wr_min) breath_min_brightness <= reg_wdata;
         if (wr_red) shared_red_mix <= reg_wdata;
         if (wr_grn) shared_green_mix <= reg_wdata;
         if (wr_blu) shared_blue_mix <= reg_wdata;
         if (wr_ge) triple_mode_enable_low <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // field decode
   wire pattern_controller_enable = pattern_config[`BPG_CFG_EN];
   wire auto_mode = pattern_config[`BPG_CFG_AUTO];
   wire manual_on = pattern_config[`BPG_CFG_SWITCH];
   wire [3:0] fall_code = pattern_fall_hold_off_timer[`BPG_FALL_MSB:`BPG_FALL_LSB];
   wire [3:0] off_code = pattern_fall_hold_off_timer[`BPG_OFF_MSB:`BPG_OFF_LSB];
   wire [1:0] end_point_select = pattern_loop_endpoints_count_high[`BPG_END_MSB:`BPG_END_LSB];
   wire [1:0] start_point_select = pattern_loop_endpoints_count_high[`BPG_START_MSB:`BPG_START_LSB];
   wire [11:0] repeat_count = {pattern_loop_endpoints_count_high[`BPG_RPT_HI_MSB:`BPG_RPT_HI_LSB],
                               pattern_repeat_count_low};
   // leaving auto mode or disabling the controller aborts a running pattern
   wire auto_ok = pattern_controller_enable && auto_mode;

   ////////////////////////////////////////////////////////////////////////////
   // tick of 10 ms
   logic [31:0] tick_cnt;
   wire tick = tick_cnt == TICK_CYCLES - 1;

   always_ff @(posedge mclk) begin
      if (rst) tick_cnt <= '0;
      else tick_cnt <= tick ? '0 : tick_cnt + 32'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // phase sequencer
   bpg_phase_t phase;
   bpg_phase_t start_ph;
   bpg_phase_t succ_ph;
   bpg_phase_t enter_ph;
   logic [11:0] loop_cnt;
   logic timer_done;
   logic [`BPG_DUR_W-1:0] dur;

   // a fresh pattern needs the run bit to go from zero to one
   wire run_start = wr_run && reg_wdata[`BPG_RUN_BIT] && !run_bit && auto_ok;

   assign start_ph = start_point_select == `BPG_START_RISE ? PH_RISE :
                     start_point_select == `BPG_START_ON ? PH_ON :
                     start_point_select == `BPG_START_FALL ? PH_FALL : PH_OFF;
   assign succ_ph = phase == PH_RISE ? PH_ON :
                    phase == PH_ON ? PH_FALL :
                    phase == PH_FALL ? PH_OFF : PH_RISE;
   assign enter_ph = run_start ? start_ph : succ_ph;

   wire phase_end = pattern_running && timer_done;
   wire pass_end = phase_end && succ_ph == start_ph;
   wire finish = pass_end && repeat_count != 12'h000 && loop_cnt + 12'h001 == repeat_count;
   wire load = run_start || (phase_end && !finish && auto_ok);
   wire [3:0] enter_code = enter_ph == PH_RISE ? rise_code :
                           enter_ph == PH_ON ? on_code :
                           enter_ph == PH_FALL ? fall_code : off_code;
   wire hold_sel = enter_ph == PH_ON || enter_ph == PH_OFF;

   always_ff @(posedge mclk) begin
      if (rst) begin
         phase <= PH_IDLE;
         loop_cnt <= 12'h000;
         pattern_running <= 1'b0;
      end else if (!auto_ok) begin
         phase <= PH_IDLE;
         pattern_running <= 1'b0;
      end else if (run_start) begin
         phase <= start_ph;
         loop_cnt <= 12'h000;
         pattern_running <= 1'b1;
      end else if (finish) begin
         phase <= PH_IDLE;
         pattern_running <= 1'b0;
      end else if (phase_end) begin
         phase <= succ_ph;
         if (pass_end) loop_cnt <= loop_cnt + 12'h001;
      end
   end

   // set wins over the clear-on-read
   always_ff @(posedge mclk) begin
      if (rst) loop_done_flag <= 1'b0;
      else if (finish) loop_done_flag <= 1'b1;
      else if (rd_run) loop_done_flag <= 1'b0;
   end

   bpg_phase_timer u_timer (
      .mclk(mclk),
      .rst(rst),
      .tick(tick),
      .load(load),
      .halt(!auto_ok),
      .hold_sel(hold_sel),
      .code(enter_code),
      .done(timer_done),
      .dur(dur)
   );

   ////////////////////////////////////////////////////////////////////////////
   // brightness ramp: credit the span each tick, spend one step per clock,
   // so a short phase over a wide span still lands on time
   logic [10:0] acc;
   wire [7:0] span = breath_max_brightness > breath_min_brightness ?
                     breath_max_brightness - breath_min_brightness : 8'h00;
   wire ramping = pattern_running && (phase == PH_RISE || phase == PH_FALL);
   wire step = ramping && dur != '0 && acc >= {1'b0, dur};
   wire [10:0] next_acc = acc + (tick ? {3'h0, span} : 11'h000) - (step ? {1'b0, dur} : 11'h000);
   wire [7:0] enter_level = enter_ph == PH_RISE || enter_ph == PH_OFF ?
                            breath_min_brightness : breath_max_brightness;
   wire [7:0] rest_level = end_point_select == `BPG_END_OFF ?
                           breath_min_brightness : breath_max_brightness;

   always_ff @(posedge mclk) begin
      if (rst) begin
         breath_level <= 8'h00;
         acc <= 11'h000;
      end else if (!auto_ok) begin
         breath_level <= manual_on ? breath_max_brightness : breath_min_brightness;
         acc <= 11'h000;
      end else if (load) begin
         breath_level <= enter_level;
         acc <= 11'h000;
      end else if (finish) begin
         breath_level <= rest_level;
      end else if (ramping) begin
         acc <= next_acc;
         if (step && phase == PH_RISE && breath_level < breath_max_brightness)
            breath_level <= breath_level + 8'h01;
         else if (step && phase == PH_FALL && breath_level > breath_min_brightness)
            breath_level <= breath_level - 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // triple modes
   bpg_triple_decode u_decode (
      .mclk(mclk),
      .rst(rst),
      .triple_mode_enable(triple_mode_enable_low),
      .pattern_controller_enable(pattern_controller_enable),
      .group_led_mask(group_led_mask),
      .pattern_led_mask(pattern_led_mask)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read port: unmapped offsets read zero
   wire [7:0] run_rd = {5'h00, loop_done_flag, pattern_running, run_bit};
   wire [7:0] rd_mux = ({8{reg_addr == `BPG_ADDR_CFG}} & pattern_config) |
                       ({8{reg_addr == `BPG_ADDR_RUN}} & run_rd) |
                       ({8{reg_addr == `BPG_ADDR_T1}} & pattern_fall_hold_off_timer) |
                       ({8{reg_addr == `BPG_ADDR_C1}} & pattern_loop_endpoints_count_high) |
                       ({8{reg_addr == `BPG_ADDR_C2}} & pattern_repeat_count_low) |
                       ({8{reg_addr == `BPG_ADDR_MAX}} & breath_max_brightness) |
                       ({8{reg_addr == `BPG_ADDR_MIN}} & breath_min_brightness) |
                       ({8{reg_addr == `BPG_ADDR_RED}} & shared_red_mix) |
                       ({8{reg_addr == `BPG_ADDR_GRN}} & shared_green_mix) |
                       ({8{reg_addr == `BPG_ADDR_BLU}} & shared_blue_mix) |
                       ({8{reg_addr == `BPG_ADDR_GE}} & triple_mode_enable_low);

   always_ff @(posedge mclk) begin
      if (rst) reg_rdata <= 8'h00;
      else if (reg_rd) reg_rdata <= rd_mux;
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   AST_END_OFF: assert property (finish && auto_ok && end_point_select == 2'h0 |=>
      breath_level == $past(breath_min_brightness))
      else $error("pattern did not rest at minimum for end point zero");
   AST_START_PHASE: assert property (run_start |=> phase == $past(start_ph) && pattern_running)
      else $error("pattern did not begin at the selected phase");
   AST_RPT_LOW: assert property (wr_c2 |=> repeat_count[7:0] == $past(reg_wdata))
      else $error("low repeat bits not taken from the written byte");
   AST_FOREVER: assert property ($rose(loop_done_flag) |-> $past(repeat_count) != 12'h000)
      else $error("pattern with zero repeat count came to an end");
   AST_ON_AT_MAX: assert property (phase == PH_ON && $past(phase) == PH_ON && auto_ok &&
      $stable(breath_max_brightness) |-> breath_level == breath_max_brightness)
      else $error("on-hold level differs from maximum");
   AST_OFF_AT_MIN: assert property (phase == PH_OFF && $past(phase) == PH_OFF && auto_ok &&
      $stable(breath_min_brightness) |-> breath_level == breath_min_brightness)
      else $error("off-hold level differs from minimum");
   AST_RED_WRITE: assert property (wr_red |=> shared_red_mix == $past(reg_wdata))
      else $error("red mix register did not take the write");
   AST_MANUAL_STOP: assert property (!auto_ok |=> !pattern_running && phase == PH_IDLE)
      else $error("pattern kept running outside auto mode");
   AST_RUN_EDGE: assert property ($rose(pattern_running) |-> $past(run_start))
      else $error("pattern started without a zero-to-one run write");
   AST_DONE_READ: assert property (rd_run && !finish |=> !loop_done_flag)
      else $error("done flag survived a read");
   AST_ORDER: assert property (phase_end && !finish && !run_start && auto_ok && phase == PH_FALL |=>
      phase == PH_OFF)
      else $error("fall phase not followed by off-hold");
   AST_RISE_BOUND: assert property (phase == PH_RISE && $past(phase) == PH_RISE &&
      $stable(breath_max_brightness) && $stable(breath_min_brightness) && span != 8'h00 |->
      breath_level <= breath_max_brightness && breath_level >= breath_min_brightness)
      else $error("rising ramp left the min-max span");

endmodule : bpg_breath_ctrl

// *** bpg_led_model.sv ***
/*
 * Behavioural model of the first LED sink behind the breath and group block.
 * Assumes the masks, level and red mix come straight from the block's ports.
 */
module bpg_led_model (
   // drive from the block
   input wire logic [23:0] group_led_mask,
   input wire logic [23:0] pattern_led_mask,
   input wire logic [7:0] breath_level,
   input wire logic [7:0] shared_red_mix,
   // duty seen on the first sink
   output logic [7:0] led1_duty
);
   timeunit 1ns;
   timeprecision 1ps;
   // pattern wins over group; a sink in neither mode carries no current
   assign led1_duty = pattern_led_mask[0] ? breath_level : (group_led_mask[0] ? shared_red_mix : 8'h00);
endmodule : bpg_led_model

// *** test_breath_pattern_group_ctrl.sv ***
/*
 * Self-checking bench for the breath pattern and group control block.
 * Assumes a short tick of 4 cycles, the on-hold code held at zero and the
 * rise code driven by the bench.
 */
`include "bpg_regs.svh"

module test_breath_pattern_group_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [3:0] rise_c = 4'h0;
   logic [7:0] reg_rdata, breath_level, red, grn, blu, led1_duty, v;
   logic [23:0] gmask, pmask;
   logic running, done;
   int num_errors = 0;
   int compares = 0;

   always #2 mclk = ~mclk;

   bpg_breath_ctrl #(.TICK_CYCLES(4)) bpg_breath_ctrl_inst (.mclk(mclk), .rst(rst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .rise_code(rise_c), .on_code(4'h0), .breath_level(breath_level), .shared_red_mix(red),
      .shared_green_mix(grn), .shared_blue_mix(blu), .group_led_mask(gmask), .pattern_led_mask(pmask),
      .pattern_running(running), .loop_done_flag(done));
   bpg_led_model bpg_led_model_inst (.group_led_mask(gmask), .pattern_led_mask(pmask),
      .breath_level(breath_level), .shared_red_mix(red), .led1_duty(led1_duty));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic get(input logic [7:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : get

   task automatic step();
      @(posedge mclk);
      #1;
   endtask : step

   // bounded wait; a missing end shows up as a done mismatch
   task automatic wait_done();
      for (int i = 0; i < 400 && done !== 1'b1; i++) step();
      check(done, 1'b1);
   endtask : wait_done

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      for (int a = 'ha5; a <= 'hab; a++) begin
         get(8'(a));
         check(v, 8'h00);
      end
      get(8'hb0);
      check(v, 8'h00);
   endtask : t_reset

   task automatic t_fields();
      wr(`BPG_ADDR_T1, 8'hf4);
      get(`BPG_ADDR_T1);
      check(v, 8'hf4);
      wr(`BPG_ADDR_RED, 8'h5a);
      wr(`BPG_ADDR_GRN, 8'h3c);
      wr(`BPG_ADDR_BLU, 8'hc3);
      #1;
      check({red, grn, blu}, 24'h5a3cc3);
      wr(`BPG_ADDR_T1, 8'h00);
   endtask : t_fields

   task automatic t_triples();
      wr(`BPG_ADDR_GE, 8'h81);
      step();
      check(gmask, 24'he00007);
      check(led1_duty, 8'h5a);
      wr(`BPG_ADDR_CFG, 8'h01);
      step();
      check(pmask, 24'he00007);
      check(gmask, 24'h000000);
   endtask : t_triples

   task automatic t_pattern();
      wr(`BPG_ADDR_MAX, 8'hc0);
      wr(`BPG_ADDR_MIN, 8'h10);
      wr(`BPG_ADDR_C1, 8'h00);
      wr(`BPG_ADDR_C2, 8'h01);
      wr(`BPG_ADDR_CFG, 8'h03);
      wr(`BPG_ADDR_RUN, 8'h01);
      #1;
      check({running, breath_level}, 9'h110);
      wait_done();
      check({running, breath_level, led1_duty}, 17'h01010);
      get(`BPG_ADDR_RUN);
      check(v, 8'h05);
      get(`BPG_ADDR_RUN);
      check(v, 8'h01);
      wr(`BPG_ADDR_RUN, 8'h01);
      step();
      check(running, 1'b0);
      wr(`BPG_ADDR_C1, 8'h60);
      wr(`BPG_ADDR_C2, 8'h02);
      wr(`BPG_ADDR_RUN, 8'h00);
      wr(`BPG_ADDR_RUN, 8'h01);
      #1;
      check(breath_level, 8'hc0);
      wait_done();
      check(breath_level, 8'hc0);
      // clear the sticky end flag so the endless loop starts clean
      get(`BPG_ADDR_RUN);
      check(v, 8'h05);
   endtask : t_pattern

   task automatic t_forever();
      wr(`BPG_ADDR_C1, 8'h00);
      wr(`BPG_ADDR_C2, 8'h00);
      wr(`BPG_ADDR_RUN, 8'h00);
      wr(`BPG_ADDR_RUN, 8'h01);
      repeat (150) step();
      check({running, done}, 2'b10);
      wr(`BPG_ADDR_CFG, 8'h09);
      step();
      check({running, breath_level}, 9'h0c0);
      wr(`BPG_ADDR_RUN, 8'h00);
   endtask : t_forever

   // fall code 1 is 13 ticks: four steps of a four-step span, two of them
   // done after 8 to 9 ticks whatever the phase of the free-running tick
   task automatic t_ramp();
      wr(`BPG_ADDR_MAX, 8'h14);
      wr(`BPG_ADDR_MIN, 8'h10);
      wr(`BPG_ADDR_T1, 8'h10);
      wr(`BPG_ADDR_C1, 8'h60);
      wr(`BPG_ADDR_C2, 8'h01);
      wr(`BPG_ADDR_CFG, 8'h03);
      rise_c <= 4'h1;
      wr(`BPG_ADDR_RUN, 8'h01);
      #1;
      check({running, breath_level}, 9'h114);
      repeat (34) step();
      check({running, breath_level}, 9'h112);
      wait_done();
      check(breath_level, 8'h14);
   endtask : t_ramp

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("errors=%0d compares=%0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      #40000;
      num_errors++;
      report_and_stop();
   end

   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_fields();
      t_triples();
      t_pattern();
      t_forever();
      t_ramp();
      report_and_stop();
   end
endmodule : test_breath_pattern_group_ctrl
